// ==== pkg/ccpc_pkg.sv ====
/*
 * Shared constants for the contactless command parameter checker.
 * Assumes a single clock domain and a plain register port with word indices.
 */
package ccpc_pkg;

    // Register word indices on the plain port.
    localparam logic [3:0] REG_SYS_CODE = 4'h0;
    localparam logic [3:0] REG_RT_SET   = 4'h1;
    localparam logic [3:0] REG_ID_LO    = 4'h2;
    localparam logic [3:0] REG_ID_HI    = 4'h3;
    localparam logic [3:0] REG_STATUS   = 4'h4;
    localparam logic [3:0] REG_POLL_CNT = 4'h5;

    // Values after reset of the settings.
    localparam logic [15:0] SYS_CODE_RST = 16'h0000;
    localparam logic [15:0] RT_SET_RST   = 16'h0000;
    localparam logic [63:0] ID_RST       = 64'h0000_0000_0000_0000;

    // Poll system codes.
    localparam logic [15:0] SC_WILDCARD  = 16'hFFFF;
    localparam logic [15:0] SC_UPPER_REQ = 16'hAAFF;
    localparam logic [7:0]  SC_UPPER_VAL = 8'hAA;

    // Fixed descriptor bytes and the reply slot.
    localparam logic [7:0] RTD_FF   = 8'hFF;
    localparam logic [7:0] RTD_00   = 8'h00;
    localparam logic [3:0] SLOT_ONE = 4'h0;

    // Status flag values.
    localparam logic [7:0] SF_OK     = 8'h00;
    localparam logic [7:0] SF_ERR    = 8'hFF;
    localparam logic [7:0] SF_SVC    = 8'hA1;
    localparam logic [7:0] SF_BLK    = 8'hA2;
    localparam logic [7:0] SF_SVCMIS = 8'hA3;
    localparam logic [7:0] SF_ELEM   = 8'hA5;

    // Service and block limits.
    localparam logic [7:0] SVC_MAX_RD = 8'h0F;
    localparam logic [7:0] SVC_MAX_WR = 8'h0B;
    localparam logic [7:0] SVC_WR_LOW = 8'h08;
    localparam logic [7:0] BLK_MAX_RD = 8'h0F;
    localparam logic [7:0] BLK_MAX_WL = 8'h0C;
    localparam logic [7:0] BLK_MAX_WH = 8'h0B;
    localparam logic [7:0] BLK_MAX_VF = 8'h01;

    // Mode codes in the third element byte.
    localparam logic [2:0] MC_PLAIN  = 3'b000;
    localparam logic [2:0] MC_VERIFY = 3'b001;
    localparam logic [2:0] MC_TUNNEL = 3'b100;

    typedef enum logic [1:0] {
        CCPC_PLAIN,
        CCPC_VERIFY,
        CCPC_TUNNEL
    } ccpc_mode_t;

endpackage

// ==== hdl/ccpc_top.sv ====
/*
 * Contactless command parameter checker: poll answer and list checks.
 * Assumes the frame layer delivers decoded fields as one-cycle strobes on clk_i.
 */
// Implementation choices: the address map and the plain strobed port.
// How it works
// - Wildcard poll code always gets an answer.
// - 0xAAFF poll matches stored upper byte only.
// - Other poll codes need exact match.
// - Answer carries stored 8-byte card identifier.
// - Descriptor bytes D0,D1,D7 FFh, D2-D4 00h.
// - D5 read setting, D6 write setting.
// - Timing byte splits exponent, multiplier, fixed term.
// - Poll answer always sent in first slot.
// - Services: read up to 15, write 11.
// - All service entries must be equal.
// - Blocks by number, 2- or 3-byte elements.
// - Access-mode bits 6..4 must be zero.
// - Bit 7 selects 2-byte form; order ignored.
// - Third byte bits 7..3 must be zero.
// - Mode code: plain, verify, tunnel; others prohibited.
// - Read carries at most 15 blocks.
// - Write 12/11 blocks by services; verify 1.
// - Element errors report FF A5.
// - Block count errors report FF A2.
// - Service count errors report FF A1.
// - Service mismatch reports FF A3.
`timescale 1ns/1ps

module ccpc_top
    import ccpc_pkg::*;
#(
    parameter int NUM_BLOCKS = 64
) (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    input  wire logic        poll_valid_i,
    input  wire logic [15:0] poll_sys_code_i,
    output logic             poll_resp_o,
    output logic      [63:0] poll_id_o,
    output logic      [63:0] poll_rtd_o,
    output logic      [3:0]  poll_slot_o,
    input  wire logic        cmd_start_i,
    input  wire logic        cmd_write_i,
    input  wire logic [7:0]  cmd_svc_cnt_i,
    input  wire logic [7:0]  cmd_blk_cnt_i,
    input  wire logic        svc_valid_i,
    input  wire logic [15:0] svc_code_i,
    input  wire logic        elem_valid_i,
    input  wire logic [7:0]  elem_byte_i,
    input  wire logic        cmd_end_i,
    output logic             chk_done_o,
    output logic      [7:0]  chk_sf1_o,
    output logic      [7:0]  chk_sf2_o,
    output logic      [1:0]  chk_mode_o,
    output logic      [1:0]  rt_exp_o,
    output logic      [2:0]  rt_mul_o,
    output logic      [2:0]  rt_fix_o
);

    ////////////////////////////////////////////////////////////////////////////

    typedef enum logic [1:0] {
        ST_D0,
        ST_NUM2,
        ST_NUM3,
        ST_MODE
    } ccpc_elem_t;

    logic        rst_s1_q;
    logic        rst_n;
    logic [15:0] sys_code_q;
    logic [15:0] rt_set_q;
    logic [63:0] id_q;
    logic [15:0] poll_cnt_q;
    logic        resp_q;
    logic [63:0] pid_q;
    logic [63:0] rtd_q;
    logic        active_q;
    logic        wr_q;
    logic [7:0]  svc_cnt_q;
    logic [7:0]  blk_cnt_q;
    logic        svc_seen_q;
    logic [15:0] svc_first_q;
    logic        svc_mis_q;
    logic        elem_err_q;
    logic        mode_set_q;
    ccpc_mode_t  mode_q;
    ccpc_elem_t  est_q;
    logic        done_q;
    logic [7:0]  sf1_q;
    logic [7:0]  sf2_q;
    logic [7:0]  rt_byte_q;
    logic [31:0] rdata_q;
    logic        poll_hit;
    logic        num_bad;
    logic        mode_bad;
    ccpc_mode_t  emode;
    logic        svc_bad;
    logic        blk_bad;
    logic [7:0]  blk_max;
    logic [7:0]  sf2_d;

    // Poll match decision on the requested system code.
    function automatic logic sc_match(input logic [15:0] req, input logic [15:0] sc);
        if (req == SC_WILDCARD) begin
            return 1'b1;
        end else if (req == SC_UPPER_REQ) begin
            return sc[15:8] == SC_UPPER_VAL;
        end
        return req == sc;
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sys_code_q <= SYS_CODE_RST;
            rt_set_q   <= RT_SET_RST;
            id_q       <= ID_RST;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                REG_SYS_CODE: sys_code_q <= reg_wdata_i[15:0];
                REG_RT_SET:   rt_set_q   <= reg_wdata_i[15:0];
                REG_ID_LO:    id_q[31:0] <= reg_wdata_i;
                REG_ID_HI:    id_q[63:32] <= reg_wdata_i;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_SYS_CODE: rdata_q <= {16'h0000, sys_code_q};
                REG_RT_SET:   rdata_q <= {16'h0000, rt_set_q};
                REG_ID_LO:    rdata_q <= id_q[31:0];
                REG_ID_HI:    rdata_q <= id_q[63:32];
                REG_STATUS:   rdata_q <= {14'h0000, chk_mode_o, sf1_q, sf2_q};
                REG_POLL_CNT: rdata_q <= {16'h0000, poll_cnt_q};
                default:      rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////////

    assign poll_hit = poll_valid_i && sc_match(poll_sys_code_i, sys_code_q);

    // A miss only clears resp_q, so nothing is sent and nothing else moves.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            resp_q     <= 1'b0;
            pid_q      <= ID_RST;
            rtd_q      <= 64'h0000_0000_0000_0000;
            poll_cnt_q <= 16'h0000;
        end else begin
            resp_q <= poll_hit;
            if (poll_hit) begin
                pid_q      <= id_q;
                rtd_q      <= {RTD_FF, RTD_FF, RTD_00, RTD_00, RTD_00,
                               rt_set_q[7:0], rt_set_q[15:8], RTD_FF};
                poll_cnt_q <= poll_cnt_q + 16'h0001;
            end
        end
    end

    assign poll_resp_o = resp_q;
    assign poll_id_o   = pid_q;
    assign poll_rtd_o  = rtd_q;
    assign poll_slot_o = SLOT_ONE;

    ////////////////////////////////////////////////////////////////////////////

    // Timing fields of the parameter that applies to the current command.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rt_byte_q <= 8'h00;
        end else if (cmd_start_i) begin
            rt_byte_q <= cmd_write_i ? rt_set_q[15:8] : rt_set_q[7:0];
        end
    end

    assign rt_exp_o = rt_byte_q[7:6];
    assign rt_mul_o = rt_byte_q[5:3];
    assign rt_fix_o = rt_byte_q[2:0];

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            active_q  <= 1'b0;
            wr_q      <= 1'b0;
            svc_cnt_q <= 8'h00;
            blk_cnt_q <= 8'h00;
        end else if (cmd_start_i) begin
            active_q  <= 1'b1;
            wr_q      <= cmd_write_i;
            svc_cnt_q <= cmd_svc_cnt_i;
            blk_cnt_q <= cmd_blk_cnt_i;
        end else if (cmd_end_i) begin
            active_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            svc_seen_q  <= 1'b0;
            svc_first_q <= 16'h0000;
            svc_mis_q   <= 1'b0;
        end else if (cmd_start_i) begin
            svc_seen_q <= 1'b0;
            svc_mis_q  <= 1'b0;
        end else if (active_q && svc_valid_i) begin
            svc_seen_q <= 1'b1;
            if (!svc_seen_q) begin
                svc_first_q <= svc_code_i;
            end else if (svc_code_i != svc_first_q) begin
                svc_mis_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Block number beyond the memory, and mode decode of the third byte.
    always_comb begin
        num_bad  = int'(elem_byte_i) >= NUM_BLOCKS;
        mode_bad = elem_byte_i[7:3] != 5'h00;
        emode    = CCPC_PLAIN;
        unique case (elem_byte_i[2:0])
            MC_PLAIN:  emode = CCPC_PLAIN;
            MC_VERIFY: begin
                emode = CCPC_VERIFY;
                if (!wr_q) begin
                    mode_bad = 1'b1;
                end
            end
            MC_TUNNEL: emode = CCPC_TUNNEL;
            default:   mode_bad = 1'b1;
        endcase
        if (est_q == ST_NUM2) begin
            emode = CCPC_PLAIN;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            est_q      <= ST_D0;
            elem_err_q <= 1'b0;
            mode_set_q <= 1'b0;
            mode_q     <= CCPC_PLAIN;
        end else if (cmd_start_i) begin
            est_q      <= ST_D0;
            elem_err_q <= 1'b0;
            mode_set_q <= 1'b0;
            mode_q     <= CCPC_PLAIN;
        end else if (active_q && elem_valid_i) begin
            unique case (est_q)
                ST_D0: begin
                    if (elem_byte_i[6:4] != 3'b000) begin
                        elem_err_q <= 1'b1;
                    end
                    est_q <= elem_byte_i[7] ? ST_NUM2 : ST_NUM3;
                end
                ST_NUM2, ST_NUM3: begin
                    if (num_bad) begin
                        elem_err_q <= 1'b1;
                    end
                    est_q <= (est_q == ST_NUM2) ? ST_D0 : ST_MODE;
                    if (est_q == ST_NUM2) begin
                        mode_set_q <= 1'b1;
                        mode_q     <= emode;
                        if (mode_set_q && mode_q != CCPC_PLAIN) begin
                            elem_err_q <= 1'b1;
                        end
                    end
                end
                ST_MODE: begin
                    est_q      <= ST_D0;
                    mode_set_q <= 1'b1;
                    mode_q     <= emode;
                    if (mode_bad || (mode_set_q && mode_q != emode)) begin
                        elem_err_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        if (wr_q) begin
            svc_bad = svc_cnt_q == 8'h00 || svc_cnt_q > SVC_MAX_WR;
            if (mode_q == CCPC_VERIFY) begin
                blk_max = BLK_MAX_VF;
            end else if (svc_cnt_q <= SVC_WR_LOW) begin
                blk_max = BLK_MAX_WL;
            end else begin
                blk_max = BLK_MAX_WH;
            end
        end else begin
            svc_bad = svc_cnt_q == 8'h00 || svc_cnt_q > SVC_MAX_RD;
            blk_max = BLK_MAX_RD;
        end
        blk_bad = blk_cnt_q == 8'h00 || blk_cnt_q > blk_max;
        if (svc_bad) begin
            sf2_d = SF_SVC;
        end else if (svc_mis_q && svc_cnt_q > 8'h01) begin
            sf2_d = SF_SVCMIS;
        end else if (blk_bad) begin
            sf2_d = SF_BLK;
        end else if (elem_err_q || est_q != ST_D0) begin
            sf2_d = SF_ELEM;
        end else begin
            sf2_d = SF_OK;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            sf1_q  <= SF_OK;
            sf2_q  <= SF_OK;
        end else begin
            done_q <= active_q && cmd_end_i && !cmd_start_i;
            if (active_q && cmd_end_i && !cmd_start_i) begin
                sf2_q <= sf2_d;
                sf1_q <= (sf2_d == SF_OK) ? SF_OK : SF_ERR;
            end
        end
    end

    assign chk_done_o = done_q;
    assign chk_sf1_o  = sf1_q;
    assign chk_sf2_o  = sf2_q;
    assign chk_mode_o = mode_q;

    ////////////////////////////////////////////////////////////////////////////

    property p_wild;
        @(posedge clk_i) disable iff (!rst_n)
        poll_valid_i && poll_sys_code_i == SC_WILDCARD |=> poll_resp_o;
    endproperty
    a_wild: assert property (p_wild) else $error("wildcard poll not answered");

    property p_upper;
        @(posedge clk_i) disable iff (!rst_n)
        poll_valid_i && poll_sys_code_i == SC_UPPER_REQ |=> poll_resp_o == ($past(sys_code_q[15:8]) == SC_UPPER_VAL);
    endproperty
    a_upper: assert property (p_upper) else $error("upper byte poll answer wrong");

    property p_exact;
        @(posedge clk_i) disable iff (!rst_n)
        poll_valid_i && poll_sys_code_i != SC_WILDCARD && poll_sys_code_i != SC_UPPER_REQ
        |=> poll_resp_o == ($past(poll_sys_code_i) == $past(sys_code_q));
    endproperty
    a_exact: assert property (p_exact) else $error("exact poll answer wrong");

    property p_id;
        @(posedge clk_i) disable iff (!rst_n)
        poll_resp_o |-> poll_id_o == $past(id_q) && poll_slot_o == SLOT_ONE;
    endproperty
    a_id: assert property (p_id) else $error("poll identifier or slot wrong");

    property p_rtd;
        @(posedge clk_i) disable iff (!rst_n)
        poll_resp_o |-> poll_rtd_o[63:40] == 24'hFF_FF00 && poll_rtd_o[39:24] == {RTD_00, RTD_00}
        && poll_rtd_o[7:0] == RTD_FF && poll_rtd_o[23:8] == {$past(rt_set_q[7:0]), $past(rt_set_q[15:8])};
    endproperty
    a_rtd: assert property (p_rtd) else $error("descriptor bytes wrong");

    property p_miss;
        @(posedge clk_i) disable iff (!rst_n)
        !poll_hit |=> !poll_resp_o && $stable(poll_cnt_q) && $stable(poll_id_o);
    endproperty
    a_miss: assert property (p_miss) else $error("missed poll changed state");

    property p_svc;
        @(posedge clk_i) disable iff (!rst_n)
        active_q && cmd_end_i && !cmd_start_i && svc_bad |=> chk_done_o && chk_sf1_o == SF_ERR && chk_sf2_o == SF_SVC;
    endproperty
    a_svc: assert property (p_svc) else $error("service count error not reported");

    property p_blk;
        @(posedge clk_i) disable iff (!rst_n)
        active_q && cmd_end_i && !cmd_start_i && !svc_bad && !svc_mis_q && wr_q && mode_q == CCPC_VERIFY
        && blk_cnt_q > BLK_MAX_VF |=> chk_sf2_o == SF_BLK;
    endproperty
    a_blk: assert property (p_blk) else $error("verify block limit not enforced");

    property p_elem;
        @(posedge clk_i) disable iff (!rst_n)
        active_q && elem_valid_i && !cmd_start_i && est_q == ST_D0 && elem_byte_i[6:4] != 3'b000
        |=> elem_err_q;
    endproperty
    a_elem: assert property (p_elem) else $error("access mode error missed");

    c_poll_hit: cover property (@(posedge clk_i) disable iff (!rst_n) poll_resp_o);
    c_ok:       cover property (@(posedge clk_i) disable iff (!rst_n) chk_done_o && chk_sf2_o == SF_OK);
    c_mis:      cover property (@(posedge clk_i) disable iff (!rst_n) chk_done_o && chk_sf2_o == SF_SVCMIS);
    c_tunnel:   cover property (@(posedge clk_i) disable iff (!rst_n) chk_done_o && chk_mode_o == CCPC_TUNNEL);

endmodule

// ==== tb/ccpc_rdr_model.sv ====
/*
 * Reader/writer model that drives poll and command strobes into the checker.
 * Assumes the caller starts each task right after a rising edge of clk_i.
 */
`timescale 1ns/1ps

module ccpc_rdr_model (
    input  wire logic        clk_i,
    output logic             poll_valid_o,
    output logic      [15:0] poll_sys_code_o,
    output logic             cmd_start_o,
    output logic             cmd_write_o,
    output logic      [7:0]  cmd_svc_cnt_o,
    output logic      [7:0]  cmd_blk_cnt_o,
    output logic             svc_valid_o,
    output logic      [15:0] svc_code_o,
    output logic             elem_valid_o,
    output logic      [7:0]  elem_byte_o,
    output logic             cmd_end_o
);
    initial begin
        {poll_valid_o, cmd_start_o, cmd_write_o, svc_valid_o, elem_valid_o, cmd_end_o} = 6'h00;
        {poll_sys_code_o, svc_code_o} = 32'h0000_0000;
        {cmd_svc_cnt_o, cmd_blk_cnt_o, elem_byte_o} = 24'h00_0000;
    end

    // Longest response wait, in units of 256x16 carrier periods.
    function automatic longint max_wait(input logic [7:0] p, input logic [7:0] n);
        max_wait = ((longint'(p[5:3]) + 1) * n + longint'(p[2:0]) + 1) << (2 * p[7:6]);
    endfunction

    task automatic poll(input logic [15:0] code);
        @(posedge clk_i);
        poll_valid_o    <= 1'b1;
        poll_sys_code_o <= code;
        @(posedge clk_i);
        poll_valid_o    <= 1'b0;
        poll_sys_code_o <= ~code;
    endtask

    // Sends counts, services and elements; diff spoils the last service on purpose.
    task automatic send_cmd(input logic wr, input logic [7:0] ns, input logic [7:0] nb, input logic diff,
                            input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
        @(posedge clk_i);
        cmd_start_o   <= 1'b1;
        cmd_write_o   <= wr;
        cmd_svc_cnt_o <= ns;
        cmd_blk_cnt_o <= nb;
        @(posedge clk_i);
        cmd_start_o <= 1'b0;
        for (int i = 0; i < ns; i++) begin
            svc_valid_o <= 1'b1;
            svc_code_o  <= (diff && i == ns - 1) ? 16'hEDCB : 16'h1234;
            @(posedge clk_i);
        end
        svc_valid_o <= 1'b0;
        svc_code_o  <= ~svc_code_o;
        for (int j = 0; j < nb; j++) begin
            for (int k = 0; k < (b0[7] ? 2 : 3); k++) begin
                elem_valid_o <= 1'b1;
                elem_byte_o  <= (k == 0) ? b0 : ((k == 1) ? b1 : b2);
                @(posedge clk_i);
            end
        end
        elem_valid_o <= 1'b0;
        elem_byte_o  <= ~elem_byte_o;
        cmd_end_o    <= 1'b1;
        @(posedge clk_i);
        cmd_end_o    <= 1'b0;
    endtask
endmodule

// ==== tb/tb_contactless_cmd_param_checker.sv ====
/*
 * Self-checking bench for the command parameter checker.
 * Assumes the reader model for the RF side and a plain register port.
 */
`timescale 1ns/1ps

`define CHK(got, want) begin compares++; if ((got) !== (want)) begin fail_count++; \
    $display("unexpected at %0t: got %0h want %0h", $time, got, want); end end

module tb_contactless_cmd_param_checker import ccpc_pkg::*;;
    typedef struct packed {
        logic       wr;
        logic [7:0] ns;
        logic [7:0] nb;
        logic       diff;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] sf2;
        logic [1:0] mode;
    } ccpc_row_t;

    localparam logic [7:0] RT_R = 8'h5A;
    localparam logic [7:0] RT_W = 8'hC3;

    logic clk_i = 1'b0, arst_n_i = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
    logic pv, cs, cw, sv, ev, ce, resp_w, done_w;
    logic [15:0] pc_w, sc_w;
    logic [7:0] nsv, nbl, eb, sf1_w, sf2_w, rt_got;
    logic [1:0] mode_w, rte;
    logic [2:0] rtm, rtf;
    logic [3:0] slot_w;
    logic [63:0] id_w, rtd_w;
    int fail_count = 0, compares = 0;
    longint wait_w;
    ccpc_row_t rows [0:22] = '{
        '{0, 1, 15, 0, 8'h80, 8'h0F, 8'h00, 8'h00, 2'h0}, '{0, 1, 16, 0, 8'h80, 8'h01, 8'h00, 8'hA2, 2'h0},
        '{1, 8, 12, 0, 8'h80, 8'h02, 8'h00, 8'h00, 2'h0}, '{1, 9, 12, 0, 8'h80, 8'h02, 8'h00, 8'hA2, 2'h0},
        '{1, 11, 11, 0, 8'h80, 8'h02, 8'h00, 8'h00, 2'h0}, '{1, 12, 1, 0, 8'h80, 8'h02, 8'h00, 8'hA1, 2'h0},
        '{0, 15, 1, 0, 8'h80, 8'h02, 8'h00, 8'h00, 2'h0}, '{0, 16, 1, 0, 8'h80, 8'h02, 8'h00, 8'hA1, 2'h0},
        '{0, 0, 1, 0, 8'h80, 8'h02, 8'h00, 8'hA1, 2'h0}, '{1, 1, 1, 0, 8'h00, 8'h03, 8'h01, 8'h00, 2'h1},
        '{1, 1, 2, 0, 8'h00, 8'h03, 8'h01, 8'hA2, 2'h0}, '{0, 1, 1, 0, 8'h00, 8'h03, 8'h01, 8'hA5, 2'h0},
        '{0, 1, 15, 0, 8'h00, 8'h03, 8'h04, 8'h00, 2'h2}, '{1, 1, 1, 0, 8'h00, 8'h03, 8'h02, 8'hA5, 2'h0},
        '{1, 1, 1, 0, 8'h90, 8'h03, 8'h00, 8'hA5, 2'h0}, '{1, 1, 1, 0, 8'h8F, 8'h03, 8'h00, 8'h00, 2'h0},
        '{1, 1, 1, 0, 8'h00, 8'h03, 8'h08, 8'hA5, 2'h0}, '{1, 1, 1, 0, 8'h80, 8'h10, 8'h00, 8'hA5, 2'h0},
        '{1, 1, 12, 0, 8'h00, 8'h03, 8'h00, 8'h00, 2'h0}, '{0, 2, 1, 1, 8'h80, 8'h03, 8'h00, 8'hA3, 2'h0},
        '{0, 16, 16, 1, 8'h90, 8'h03, 8'h00, 8'hA1, 2'h0}, '{0, 2, 16, 1, 8'h90, 8'h03, 8'h00, 8'hA3, 2'h0},
        '{0, 1, 16, 0, 8'h90, 8'h03, 8'h00, 8'hA2, 2'h0}};
    logic [15:0] pcode [0:4] = '{16'hFFFF, 16'hAAFF, 16'hAA34, 16'hAA35, 16'h34AA};
    logic pwant [0:4] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

    assign rt_got = {rte, rtm, rtf};

    always #50 clk_i = ~clk_i;

    ccpc_rdr_model rdr (.clk_i(clk_i), .poll_valid_o(pv), .poll_sys_code_o(pc_w), .cmd_start_o(cs),
        .cmd_write_o(cw), .cmd_svc_cnt_o(nsv), .cmd_blk_cnt_o(nbl), .svc_valid_o(sv), .svc_code_o(sc_w),
        .elem_valid_o(ev), .elem_byte_o(eb), .cmd_end_o(ce));

    ccpc_top #(.NUM_BLOCKS(16)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .poll_valid_i(pv), .poll_sys_code_i(pc_w), .poll_resp_o(resp_w), .poll_id_o(id_w), .poll_rtd_o(rtd_w),
        .poll_slot_o(slot_w), .cmd_start_i(cs), .cmd_write_i(cw), .cmd_svc_cnt_i(nsv), .cmd_blk_cnt_i(nbl),
        .svc_valid_i(sv), .svc_code_i(sc_w), .elem_valid_i(ev), .elem_byte_i(eb), .cmd_end_i(ce),
        .chk_done_o(done_w), .chk_sf1_o(sf1_w), .chk_sf2_o(sf2_w), .chk_mode_o(mode_w),
        .rt_exp_o(rte), .rt_mul_o(rtm), .rt_fix_o(rtf));

    ////////////////////////////////////////
    task automatic tally_and_finish;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_i);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_check(input logic [3:0] a, input logic [31:0] want);
        @(posedge clk_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_i);
        reg_rd   <= 1'b0;
        #1 `CHK(reg_rdata, want)
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        `CHK(slot_w, SLOT_ONE)
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        reg_check(REG_SYS_CODE, {16'h0000, SYS_CODE_RST});
        reg_check(4'hF, 32'h0000_0000);
        reg_write(REG_STATUS, 32'hFFFF_FFFF);
        reg_check(REG_STATUS, 32'h0000_0000);
        reg_write(REG_RT_SET, {16'h0000, RT_W, RT_R});
        reg_write(REG_ID_LO, 32'h89AB_CDEF);
        reg_write(REG_ID_HI, 32'h0123_4567);
        reg_write(REG_SYS_CODE, 32'h0000_AA34);
        reg_check(REG_RT_SET, {16'h0000, RT_W, RT_R});
        reg_check(REG_ID_LO, 32'h89AB_CDEF);
        reg_check(REG_ID_HI, 32'h0123_4567);
        for (int i = 0; i < 23; i++) begin
            rdr.send_cmd(rows[i].wr, rows[i].ns, rows[i].nb, rows[i].diff, rows[i].b0, rows[i].b1, rows[i].b2);
            #1 `CHK(done_w, 1'b1)
            `CHK(sf1_w, (rows[i].sf2 === SF_OK) ? SF_OK : SF_ERR)
            `CHK(sf2_w, rows[i].sf2)
            if (rows[i].sf2 === SF_OK) `CHK(mode_w, rows[i].mode)
            `CHK(rt_got, rows[i].wr ? RT_W : RT_R)
            wait_w = rows[i].wr ? (rows[i].nb + 4) * 64 : (rows[i].nb * 4 + 3) * 4;
            `CHK(rdr.max_wait(rt_got, rows[i].nb), wait_w)
        end
        @(posedge clk_i);
        #1 `CHK(done_w, 1'b0)
        reg_check(REG_STATUS, 32'h0000_FFA2);
        for (int i = 0; i < 5; i++) begin
            rdr.poll(pcode[i]);
            #1 `CHK(resp_w, pwant[i])
        end
        `CHK(id_w, 64'h0123_4567_89AB_CDEF)
        `CHK(rtd_w, {RTD_FF, RTD_FF, RTD_00, RTD_00, RTD_00, RT_R, RT_W, RTD_FF})
        `CHK(slot_w, SLOT_ONE)
        reg_check(REG_POLL_CNT, 32'h0000_0003);
        reg_write(REG_SYS_CODE, 32'h0000_12AB);
        reg_write(REG_ID_HI, 32'h7654_3210);
        rdr.poll(16'hAAFF);
        #1 `CHK(resp_w, 1'b0)
        `CHK(id_w, 64'h0123_4567_89AB_CDEF)
        reg_check(REG_POLL_CNT, 32'h0000_0003);
        rdr.poll(16'h12AB);
        #1 `CHK(resp_w, 1'b1)
        `CHK(id_w, 64'h7654_3210_89AB_CDEF)
        @(posedge clk_i);
        #1 `CHK(resp_w, 1'b0)
        arst_n_i <= 1'b0;
        @(posedge clk_i);
        #1 `CHK(id_w, 64'h0000_0000_0000_0000)
        `CHK(sf1_w, SF_OK)
        tally_and_finish();
    end
endmodule
